// >>> verilog/fdcr_regs.sv
// Purpose: output control, status B and tape registers with drive decode
// Assumes: host strobes are one-cycle pulses synchronous to CLK_SYS_IN
// Notes: read data and enables appear one cycle after the read strobe
`timescale 1ns/10ps
`include "fdcr_defines.svh"
module fdcr_regs (
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic RD_STB_IN,
  input wire logic WR_STB_IN,
  input wire logic [2:0] MODE_IN,
  input wire logic SWAP_DRIVES_IN,
  input wire logic TAPE_ENH_IN,
  input wire logic [7:0] CFG_F1_IN,
  input wire logic [7:0] CFG_F2_IN,
  input wire logic [1:0] MEDIA_ID_IN,
  input wire logic RD_DATA_IN,
  input wire logic WR_DATA_IN,
  input wire logic WRITE_GATE_IN,
  input wire logic SECOND_DRIVE_PRESENT_LOW_IN,
  input wire logic DMA_REQUEST_IN,
  input wire logic IRQ_IN,
  input wire logic DMA_ACK_LOW_IN,
  input wire logic TRANSFER_END_COUNT_IN,
  output logic [7:0] DATA_OUT,
  output logic [7:0] DATA_OE_OUT,
  output logic DRIVE_SEL0_LOW_OUT,
  output logic DRIVE_SEL1_LOW_OUT,
  output logic DRIVE_SEL2_LOW_OUT,
  output logic DRIVE_SEL3_LOW_OUT,
  output logic [3:0] MOTOR_ON_LOW_OUT,
  output logic SOFT_RST_OUT,
  output logic DMA_REQUEST_OUT,
  output logic DMA_REQUEST_OE_OUT,
  output logic IRQ_OUT,
  output logic IRQ_OE_OUT,
  output logic DMA_ACK_LOW_OUT,
  output logic TRANSFER_END_COUNT_OUT
);
  logic [7:0] out_ctrl;
  logic [7:0] next_out_ctrl;
  logic [1:0] tape_sel;
  logic [1:0] next_tape_sel;
  logic rd_toggle, wr_toggle, next_rd_toggle, next_wr_toggle;
  logic wg_latch, rd_latch, wd_latch;
  logic next_wg_latch, next_rd_latch, next_wd_latch;
  fdcr_pkg::fdcr_sr_t sr_state, next_sr_state;
  logic [2:0] sr_cnt, next_sr_cnt;
  logic [7:0] next_data, next_oe;
  logic [3:0] next_sel_low, next_mot_low, sel_low;
  logic next_soft_rst, next_dma_en_pins;
  logic next_drq, next_drq_oe, next_irq, next_irq_oe, next_dack_low, next_tc;
  logic rd_fall, wd_fall, wg_rise;
  logic wr_ctrl, wr_tape, rd_din;
  logic [7:0] status_b;
  logic [7:0] tape_read;
  logic [1:0] type_id;

  // edge detectors on drive-side signals
  fdcr_edge #(.RISE(1'b0)) u_rd_edge (
    .clk_in(CLK_SYS_IN), .rst_in(SYS_RST_IN), .sig_in(RD_DATA_IN), .pulse_out(rd_fall));
  fdcr_edge #(.RISE(1'b0)) u_wd_edge (
    .clk_in(CLK_SYS_IN), .rst_in(SYS_RST_IN), .sig_in(WR_DATA_IN), .pulse_out(wd_fall));
  fdcr_edge #(.RISE(1'b1)) u_wg_edge (
    .clk_in(CLK_SYS_IN), .rst_in(SYS_RST_IN), .sig_in(WRITE_GATE_IN), .pulse_out(wg_rise));

  // access decode
  assign wr_ctrl = WR_STB_IN & (ADDR_IN == `FDCR_OFF_OUT_CTRL);
  assign wr_tape = WR_STB_IN & (ADDR_IN == `FDCR_OFF_TAPE);
  assign rd_din = RD_STB_IN & (ADDR_IN == `FDCR_OFF_DIN);

  // register writes
  always_comb begin
    next_out_ctrl = out_ctrl;
    next_tape_sel = tape_sel;
    // [RL9] always writable control
    if (wr_ctrl) begin
      next_out_ctrl = DATA_IN;
    end
    // [RL19] [RL21] stored tape select only
    if (wr_tape) begin
      next_tape_sel = DATA_IN[1:0];
    end
  end
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      out_ctrl <= `FDCR_OUT_CTRL_RESET;
      tape_sel <= `FDCR_TAPE_RESET;
    end else begin
      out_ctrl <= next_out_ctrl;
      tape_sel <= next_tape_sel;
    end
  end

  // drive status toggles and latches
  always_comb begin
    // [RL1] read data toggle
    next_rd_toggle = rd_toggle ^ rd_fall;
    // [RL2] write data toggle
    next_wr_toggle = wr_toggle ^ wd_fall;
    // [RL6] write gate latch, set beats clear
    next_wg_latch = wg_rise | (wg_latch & ~rd_din);
    // [RL7] read data latch
    next_rd_latch = rd_fall | (rd_latch & ~rd_din);
    // [RL8] write data latch, not gated by write gate
    next_wd_latch = wd_fall | (wd_latch & ~rd_din);
  end
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rd_toggle <= 1'b0;
      wr_toggle <= 1'b0;
      wg_latch <= 1'b0;
      rd_latch <= 1'b0;
      wd_latch <= 1'b0;
    end else begin
      rd_toggle <= next_rd_toggle;
      wr_toggle <= next_wr_toggle;
      wg_latch <= next_wg_latch;
      rd_latch <= next_rd_latch;
      wd_latch <= next_wd_latch;
    end
  end

  // soft reset sequencer: held while bit low, then stretched to the minimum
  always_comb begin
    next_sr_state = sr_state;
    next_sr_cnt = sr_cnt;
    case (sr_state)
      fdcr_pkg::FDCR_SR_RUN: begin
        // [RL11] zero written starts the hold
        if (!next_out_ctrl[`FDCR_BIT_NRST]) begin
          next_sr_state = fdcr_pkg::FDCR_SR_HOLD;
          next_sr_cnt = 3'(`FDCR_SRST_CYCLES - 1);
        end
      end
      fdcr_pkg::FDCR_SR_HOLD: begin
        if (sr_cnt != 3'h0) begin
          next_sr_cnt = sr_cnt - 3'h1;
        end
        // [RL12] back-to-back release still waits out the minimum
        if (next_out_ctrl[`FDCR_BIT_NRST]) begin
          next_sr_state = (sr_cnt != 3'h0) ? fdcr_pkg::FDCR_SR_STRETCH
                                          : fdcr_pkg::FDCR_SR_RUN;
        end
      end
      fdcr_pkg::FDCR_SR_STRETCH: begin
        if (sr_cnt != 3'h0) begin
          next_sr_cnt = sr_cnt - 3'h1;
        end
        if (!next_out_ctrl[`FDCR_BIT_NRST]) begin
          next_sr_state = fdcr_pkg::FDCR_SR_HOLD;
        end else if (sr_cnt == 3'h0) begin
          next_sr_state = fdcr_pkg::FDCR_SR_RUN;
        end
      end
      default: begin
        next_sr_state = fdcr_pkg::FDCR_SR_HOLD;
        next_sr_cnt = 3'(`FDCR_SRST_CYCLES - 1);
      end
    endcase
  end
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      sr_state <= fdcr_pkg::FDCR_SR_HOLD;
      sr_cnt <= 3'(`FDCR_SRST_CYCLES - 1);
    end else begin
      sr_state <= next_sr_state;
      sr_cnt <= next_sr_cnt;
    end
  end

  // drive select and motor decode
  always_comb begin
    // [RL10] [RL16] one select from the binary drive number
    next_sel_low = 4'hf;
    case (next_out_ctrl[1:0])
      2'h0: next_sel_low[0] = ~next_out_ctrl[`FDCR_BIT_MOT0];
      2'h1: next_sel_low[1] = ~next_out_ctrl[`FDCR_BIT_MOT1];
      2'h2: next_sel_low[2] = ~next_out_ctrl[`FDCR_BIT_MOT2];
      2'h3: next_sel_low[3] = ~next_out_ctrl[`FDCR_BIT_MOT3];
      default: next_sel_low = 4'hf;
    endcase
    // [RL15] motor bits drive active-low motor outputs
    next_mot_low = ~next_out_ctrl[7:4];
    // [RL17] swapped decode exchanges drives 0 and 1
    if (SWAP_DRIVES_IN) begin
      next_sel_low[1:0] = {next_sel_low[0], next_sel_low[1]};
      next_mot_low[1:0] = {next_mot_low[0], next_mot_low[1]};
    end
  end

  // dma and interrupt pin gating
  always_comb begin
    // [RL13] [RL14] bit 3 gates pins except in second-gen mode
    next_dma_en_pins = (MODE_IN == fdcr_pkg::FDCR_MODE_GEN2) |
                       next_out_ctrl[`FDCR_BIT_DMA_IRQ_GATE_BIT];
    next_drq = DMA_REQUEST_IN;
    next_irq = IRQ_IN;
    next_drq_oe = next_dma_en_pins;
    next_irq_oe = next_dma_en_pins;
    next_dack_low = next_dma_en_pins ? DMA_ACK_LOW_IN : 1'b1;
    next_tc = next_dma_en_pins & TRANSFER_END_COUNT_IN;
    next_soft_rst = (next_sr_state != fdcr_pkg::FDCR_SR_RUN);
  end

  // status B contents per mode
  always_comb begin
    status_b = 8'h00;
    if (MODE_IN == fdcr_pkg::FDCR_MODE_COMPACT) begin
      // [RL5] compact layout from select pins
      status_b = {SECOND_DRIVE_PRESENT_LOW_IN, sel_low[1], sel_low[0], wd_latch,
                  rd_latch, wg_latch, sel_low[3], sel_low[2]};
    end else begin
      // [RL3] [RL4] second-gen layout
      status_b = {2'b11, out_ctrl[`FDCR_BIT_SEL0], wr_toggle, rd_toggle,
                  WRITE_GATE_IN, out_ctrl[`FDCR_BIT_MOT1], out_ctrl[`FDCR_BIT_MOT0]};
    end
  end

  // tape register read value
  always_comb begin
    // [RL24] drive type pair picked by drive number
    case (out_ctrl[1:0])
      2'h0: type_id = CFG_F2_IN[1:0];
      2'h1: type_id = CFG_F2_IN[3:2];
      2'h2: type_id = CFG_F2_IN[5:4];
      2'h3: type_id = CFG_F2_IN[7:6];
      default: type_id = 2'h0;
    endcase
    // [RL22] media id pins, polarity set by config
    tape_read = {MEDIA_ID_IN[1] ^ CFG_F1_IN[5], MEDIA_ID_IN[0] ^ CFG_F1_IN[4], type_id,
                 CFG_F1_IN[7:6], tape_sel};
  end

  // host read mux
  always_comb begin
    next_data = 8'h00;
    next_oe = `FDCR_OE_NONE;
    if (RD_STB_IN) begin
      case (ADDR_IN)
        `FDCR_OFF_STATUS_B: begin
          next_data = status_b;
          // [RL23] baseline mode leaves the bus undriven
          next_oe = (MODE_IN == fdcr_pkg::FDCR_MODE_BASE) ? `FDCR_OE_NONE : `FDCR_OE_ALL;
        end
        `FDCR_OFF_OUT_CTRL: begin
          next_data = out_ctrl;
          next_oe = `FDCR_OE_ALL;
        end
        `FDCR_OFF_TAPE: begin
          // [RL20] normal mode drives bits 1:0 only
          next_data = TAPE_ENH_IN ? tape_read : {6'h00, tape_sel};
          next_oe = TAPE_ENH_IN ? `FDCR_OE_ALL : `FDCR_OE_TAPE_NORMAL;
        end
        default: begin
          next_data = 8'h00;
          next_oe = `FDCR_OE_NONE;
        end
      endcase
    end
  end

  // output flops
  always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      DATA_OUT <= 8'h00;
      DATA_OE_OUT <= `FDCR_OE_NONE;
      sel_low <= 4'hf;
      MOTOR_ON_LOW_OUT <= 4'hf;
      SOFT_RST_OUT <= 1'b1;
      DMA_REQUEST_OUT <= 1'b0;
      DMA_REQUEST_OE_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
      IRQ_OE_OUT <= 1'b0;
      DMA_ACK_LOW_OUT <= 1'b1;
      TRANSFER_END_COUNT_OUT <= 1'b0;
    end else begin
      DATA_OUT <= next_data;
      DATA_OE_OUT <= next_oe;
      sel_low <= next_sel_low;
      MOTOR_ON_LOW_OUT <= next_mot_low;
      SOFT_RST_OUT <= next_soft_rst;
      DMA_REQUEST_OUT <= next_drq;
      DMA_REQUEST_OE_OUT <= next_drq_oe;
      IRQ_OUT <= next_irq;
      IRQ_OE_OUT <= next_irq_oe;
      DMA_ACK_LOW_OUT <= next_dack_low;
      TRANSFER_END_COUNT_OUT <= next_tc;
    end
  end
  assign DRIVE_SEL0_LOW_OUT = sel_low[0];
  assign DRIVE_SEL1_LOW_OUT = sel_low[1];
  assign DRIVE_SEL2_LOW_OUT = sel_low[2];
  assign DRIVE_SEL3_LOW_OUT = sel_low[3];

  // checks
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  AST_RD_TOGGLE: assert property (rd_fall |=> rd_toggle != $past(rd_toggle)) // [RL1]
    else $error("read toggle missed an edge");
  AST_WD_TOGGLE: assert property (!wd_fall |=> wr_toggle == $past(wr_toggle)) // [RL2]
    else $error("write toggle moved without edge");
  AST_SEL0_MIRROR: assert property ((MODE_IN == fdcr_pkg::FDCR_MODE_GEN2) && RD_STB_IN
      && ADDR_IN == `FDCR_OFF_STATUS_B |=> DATA_OUT[7:5] == {2'b11, $past(out_ctrl[0])}) // [RL3]
    else $error("status b top bits wrong");
  AST_WG_LATCH: assert property (wg_rise |=> wg_latch) // [RL6]
    else $error("write gate latch not set");
  AST_LATCH_CLEAR: assert property (rd_din && !rd_fall |=> !rd_latch) // [RL7]
    else $error("read data latch not cleared");
  AST_ONE_SEL: assert property ($countones(~sel_low) <= 1) // [RL10]
    else $error("more than one drive selected");
  AST_SRST_MIN: assert property ($rose(SOFT_RST_OUT) |-> SOFT_RST_OUT [*4]) // [RL12]
    else $error("soft reset shorter than minimum");
  AST_SRST_HOLD: assert property (!out_ctrl[`FDCR_BIT_NRST] |-> SOFT_RST_OUT) // [RL11]
    else $error("soft reset released while bit low");
  AST_GEN2_PINS: assert property (MODE_IN == fdcr_pkg::FDCR_MODE_GEN2 |=> ##0
      (IRQ_OE_OUT || $past(MODE_IN) != fdcr_pkg::FDCR_MODE_GEN2)) // [RL14]
    else $error("pins disabled in second-gen mode");
  AST_MOTOR: assert property (!SWAP_DRIVES_IN && wr_ctrl |=> MOTOR_ON_LOW_OUT ==
      ~$past(DATA_IN[7:4])) // [RL15]
    else $error("motor outputs do not follow bits");
  AST_TAPE_OE: assert property (RD_STB_IN && ADDR_IN == `FDCR_OFF_TAPE && !TAPE_ENH_IN
      |=> DATA_OE_OUT == `FDCR_OE_TAPE_NORMAL) // [RL20]
    else $error("tape upper bits driven in normal mode");
  AST_BASE_UNDRIVEN: assert property (RD_STB_IN && ADDR_IN == `FDCR_OFF_STATUS_B
      && MODE_IN == fdcr_pkg::FDCR_MODE_BASE |=> DATA_OE_OUT == `FDCR_OE_NONE) // [RL23]
    else $error("status b driven in baseline mode");

  COV_BACK_TO_BACK: cover property (wr_ctrl && !DATA_IN[2] ##1 wr_ctrl && DATA_IN[2]);
  COV_DRIVE0_ON: cover property (wr_ctrl && DATA_IN == 8'h1c);
  COV_DRIVE1_ON: cover property (wr_ctrl && DATA_IN == 8'h2d);
  COV_SET_CLEAR: cover property (rd_din && rd_fall);
endmodule

// >>> pkg/fdcr_defines.svh
// Purpose: constants of the floppy drive control/status register block
// Assumes: 40 MHz controller clock, byte-wide host bus with 3 address bits
// Notes: offsets are byte offsets from the floppy I/O base
// Functional notes
// [RL1] second-gen mode: status bit 3 toggles on each read data falling edge
// [RL2] second-gen mode: status bit 4 toggles on each write data falling edge
// [RL3] second-gen mode: status bit 5 mirrors drive select bit 0, soft reset keeps it
// [RL4] second-gen mode: status bits 7 and 6 always read one
// [RL5] compact mode: status shows select lows, second-drive pin, resets 1100011
// [RL6] compact mode: bit 2 latches write gate rising edge until input-reg read
// [RL7] compact mode: bit 3 latches read data falling edge until input-reg read
// [RL8] compact mode: bit 4 latches write data falling edge, write gate ignored
// [RL9] output control resets to zero, always writable, kept through soft reset
// [RL10] output control bits 1:0 pick one drive, one select low at most
// [RL11] bit 2 low holds soft reset until one is written; nothing else changes
// [RL12] soft reset lasts at least 100 ns, even for back-to-back 0 then 1
// [RL13] baseline/compact: bit 3 gates dma ack, count, request and interrupt
// [RL14] second-gen: dma and interrupt pins always enabled, bit 3 still reset
// [RL15] bits 7:4 each assert the matching active-low motor output
// [RL16] normal decode: drive 0 with motor 0, drive 1 with motor 1
// [RL17] swapped decode exchanges selects and motor outputs of drives 0 and 1
// [RL18] host writes 1c for drive 0 and 2d for drive 1 to start it
// [RL19] tape register steers nothing and survives soft reset
// [RL20] normal mode: tape register reads bits 1:0 only, 7:2 undriven
// [RL21] tape select code: 00 none, 01 drive 1, 10 drive 2, 11 drive 3
// [RL22] enhanced mode 2: media id pins read as bits 7:6, reset-free
// [RL23] baseline mode: status read leaves the data bus undriven
// [RL24] enhanced mode 2: bits 5:4 give drive type picked by drive number
`ifndef FDCR_DEFINES_SVH
`define FDCR_DEFINES_SVH
`define FDCR_OFF_STATUS_B 3'h1
`define FDCR_OFF_OUT_CTRL 3'h2
`define FDCR_OFF_TAPE 3'h3
`define FDCR_OFF_DIN 3'h7
`define FDCR_OUT_CTRL_RESET 8'h00
`define FDCR_TAPE_RESET 2'h0
`define FDCR_BIT_SEL0 0
`define FDCR_BIT_NRST 2
`define FDCR_BIT_DMA_IRQ_GATE_BIT 3
`define FDCR_BIT_MOT0 4
`define FDCR_BIT_MOT1 5
`define FDCR_BIT_MOT2 6
`define FDCR_BIT_MOT3 7
`define FDCR_CLK_PERIOD_NS 25
`define FDCR_SRST_MIN_NS 100
`define FDCR_SRST_CYCLES ((`FDCR_SRST_MIN_NS + `FDCR_CLK_PERIOD_NS - 1) / `FDCR_CLK_PERIOD_NS)
`define FDCR_OE_NONE 8'h00
`define FDCR_OE_ALL 8'hff
`define FDCR_OE_TAPE_NORMAL 8'h03
`endif

// >>> pkg/fdcr_pkg.sv
// Purpose: types of the floppy drive control/status register block
// Assumes: nothing beyond the defines header
// Notes: codes are one-hot
package fdcr_pkg;
  // host-selected compatibility mode
  typedef enum logic [2:0] {
    FDCR_MODE_BASE = 3'b001,
    FDCR_MODE_GEN2 = 3'b010,
    FDCR_MODE_COMPACT = 3'b100
  } fdcr_mode_t;
  // soft reset sequencer states
  typedef enum logic [2:0] {
    FDCR_SR_RUN = 3'b001,
    FDCR_SR_HOLD = 3'b010,
    FDCR_SR_STRETCH = 3'b100
  } fdcr_sr_t;
endpackage

// >>> verilog/fdcr_edge.sv
// Purpose: single-signal edge detector giving a one-cycle pulse
// Assumes: input synchronous to the clock
// Notes: RISE selects rising (1) or falling (0) edge
`timescale 1ns/10ps
module fdcr_edge #(
  parameter bit RISE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sig_in,
  output logic pulse_out
);
  logic prev;
  logic next_prev;
  // remember last level
  always_comb begin
    next_prev = sig_in;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
  // edge pulse
  assign pulse_out = RISE ? (sig_in & ~prev) : (~sig_in & prev);
endmodule

// >>> bench/fdcr_drive_model.sv
// Purpose: behavioural floppy drive pair as seen from the register block pins
// Assumes: bench clock, pins change just after a rising edge
// Notes: data lines idle low between pulses; tasks are called by the bench
`timescale 1ns/10ps
module fdcr_drive_model (
  input wire logic clk_in,
  output logic rd_data_out,
  output logic wr_data_out,
  output logic write_gate_out,
  output logic drv2_low_out,
  output logic [1:0] media_id_out
);
  // idle levels from time zero
  initial begin
    rd_data_out = 1'b0;
    wr_data_out = 1'b0;
    write_gate_out = 1'b0;
    drv2_low_out = 1'b1;
    media_id_out = 2'h0;
  end
  // one data pulse, ending on its inactive (falling) edge, then a gap cycle
  task automatic pulse(input bit wr);
    @(posedge clk_in);
    if (wr) begin
      wr_data_out <= 1'b1;
    end else begin
      rd_data_out <= 1'b1;
    end
    @(posedge clk_in);
    wr_data_out <= 1'b0;
    rd_data_out <= 1'b0;
    @(posedge clk_in);
  endtask
  // write gate level
  task automatic set_gate(input logic g);
    @(posedge clk_in);
    write_gate_out <= g;
  endtask
  // media id pins and second-drive presence
  task automatic set_static(input logic [1:0] m, input logic d2);
    @(posedge clk_in);
    media_id_out <= m;
    drv2_low_out <= d2;
  endtask
endmodule

// >>> bench/fdcr_regs_tb_top.sv
// Purpose: self-checking bench for the drive control and status registers
// Assumes: drive model on the far side, bench acts as host
// Notes: reads are noted in a queue and checked by a separate monitor
`timescale 1ns/10ps
module fdcr_regs_tb_top;
  typedef struct {logic [7:0] d; logic [7:0] oe;} fdcr_note_t;
  logic CLK_SYS_IN, SYS_RST_IN, RD_STB_IN, WR_STB_IN, SWAP_DRIVES_IN, TAPE_ENH_IN;
  logic [2:0] ADDR_IN, MODE_IN;
  logic [7:0] DATA_IN, CFG_F1_IN, CFG_F2_IN, DATA_OUT, DATA_OE_OUT;
  logic DMA_REQUEST_IN, IRQ_IN, DMA_ACK_LOW_IN, TRANSFER_END_COUNT_IN;
  logic rd_d, wr_d, wg, drv2_n;
  logic [1:0] mid;
  logic s0, s1, s2, s3, srst, dma_request, drq_oe, irq, irq_oe, ack_n, tc;
  logic [3:0] mot;
  fdcr_note_t q[$];
  fdcr_note_t e;
  int fail_count = 0;
  int comparisons = 0;
  int n;
  logic [7:0] v;

  fdcr_drive_model i_drv (.clk_in(CLK_SYS_IN), .rd_data_out(rd_d), .wr_data_out(wr_d),
    .write_gate_out(wg), .drv2_low_out(drv2_n), .media_id_out(mid));
  fdcr_regs i_dut (.CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .ADDR_IN(ADDR_IN),
    .DATA_IN(DATA_IN), .RD_STB_IN(RD_STB_IN), .WR_STB_IN(WR_STB_IN), .MODE_IN(MODE_IN),
    .SWAP_DRIVES_IN(SWAP_DRIVES_IN), .TAPE_ENH_IN(TAPE_ENH_IN), .CFG_F1_IN(CFG_F1_IN),
    .CFG_F2_IN(CFG_F2_IN), .MEDIA_ID_IN(mid), .RD_DATA_IN(rd_d), .WR_DATA_IN(wr_d),
    .WRITE_GATE_IN(wg), .SECOND_DRIVE_PRESENT_LOW_IN(drv2_n), .DMA_REQUEST_IN(DMA_REQUEST_IN),
    .IRQ_IN(IRQ_IN), .DMA_ACK_LOW_IN(DMA_ACK_LOW_IN),
    .TRANSFER_END_COUNT_IN(TRANSFER_END_COUNT_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE_OUT(DATA_OE_OUT), .DRIVE_SEL0_LOW_OUT(s0), .DRIVE_SEL1_LOW_OUT(s1),
    .DRIVE_SEL2_LOW_OUT(s2), .DRIVE_SEL3_LOW_OUT(s3), .MOTOR_ON_LOW_OUT(mot),
    .SOFT_RST_OUT(srst), .DMA_REQUEST_OUT(dma_request), .DMA_REQUEST_OE_OUT(drq_oe), .IRQ_OUT(irq),
    .IRQ_OE_OUT(irq_oe), .DMA_ACK_LOW_OUT(ack_n), .TRANSFER_END_COUNT_OUT(tc));

  // 40 MHz clock
  initial begin
    CLK_SYS_IN = 1'b0;
    forever #12.5 CLK_SYS_IN = ~CLK_SYS_IN;
  end

  // one comparison, reported at once on mismatch
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    comparisons++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // host write: strobe held for one sampling edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_IN);
    ADDR_IN <= a;
    DATA_IN <= d;
    WR_STB_IN <= 1'b1;
    @(posedge CLK_SYS_IN);
    WR_STB_IN <= 1'b0;
  endtask

  // host read: the expected byte and enables are noted for the monitor
  task automatic rd(input logic [2:0] a, input logic [7:0] d, input logic [7:0] oe);
    @(posedge CLK_SYS_IN);
    ADDR_IN <= a;
    RD_STB_IN <= 1'b1;
    q.push_back('{d, oe});
    @(posedge CLK_SYS_IN);
    RD_STB_IN <= 1'b0;
  endtask

  // expected select lows and motor lows for an output control value
  function automatic logic [7:0] pins(input logic [7:0] d, input logic sw);
    logic [3:0] sel;
    logic [3:0] m;
    sel = 4'hf;
    sel[d[1:0]] = ~d[4 + d[1:0]];
    m = ~d[7:4];
    if (sw && d[1:0] < 2'h2) begin
      sel[1:0] = {sel[0], sel[1]};
    end
    if (sw) begin
      m[1:0] = {~d[4], ~d[5]};
    end
    return {sel, m};
  endfunction

  // drive pins checked mid-cycle after a write has landed
  task automatic chk_pins(input logic [7:0] d, input logic sw);
    @(negedge CLK_SYS_IN);
    chk("drive pins", pins(d, sw), {s3, s2, s1, s0, mot});
  endtask

  // monitor: read data appears in the cycle after the sampling edge
  always @(posedge CLK_SYS_IN) begin
    if (RD_STB_IN === 1'b1) begin
      #1;
      e = q.pop_front();
      chk("read oe", e.oe, DATA_OE_OUT);
      chk("read data", e.d & e.oe, DATA_OUT & e.oe);
    end
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of under 150 cycles
  initial begin
    #(25 * 5000);
    fail_count++;
    give_verdict();
  end

  initial begin
    SYS_RST_IN = 1'b1;
    {RD_STB_IN, WR_STB_IN, SWAP_DRIVES_IN, TAPE_ENH_IN, IRQ_IN, DMA_REQUEST_IN} = 6'h00;
    {ADDR_IN, DATA_IN, MODE_IN} = {3'h0, 8'h00, 3'h1};
    DMA_ACK_LOW_IN = 1'b0;
    TRANSFER_END_COUNT_IN = 1'b1;
    void'($urandom(13056));
    CFG_F1_IN = 8'($urandom);
    CFG_F2_IN = 8'($urandom);
    repeat (6) @(posedge CLK_SYS_IN);
    SYS_RST_IN <= 1'b0;
    // reset state
    chk_pins(8'h00, 1'b0);
    chk("soft reset", 8'h01, {7'h0, srst});
    rd(3'h2, 8'h00, 8'hff);
    $display("test reset done");
    // random output control values in both decodes
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom);
      SWAP_DRIVES_IN <= i[0];
      wr(3'h2, v);
      chk_pins(v, i[0]);
    end
    SWAP_DRIVES_IN <= 1'b0;
    wr(3'h2, 8'h1c);
    chk_pins(8'h1c, 1'b0);
    wr(3'h2, 8'h2d);
    chk_pins(8'h2d, 1'b0);
    rd(3'h2, 8'h2d, 8'hff);
    $display("test decode done");
    // tape register, normal then enhanced
    for (int c = 0; c < 4; c++) begin
      wr(3'h3, {6'($urandom), 2'(c)});
      rd(3'h3, {6'h00, 2'(c)}, 8'h03);
    end
    i_drv.set_static(2'h2, 1'b0);
    TAPE_ENH_IN <= 1'b1;
    rd(3'h3, {2'h2 ^ CFG_F1_IN[5:4], CFG_F2_IN[3:2], CFG_F1_IN[7:6], 2'h3}, 8'hff);
    TAPE_ENH_IN <= 1'b0;
    $display("test tape done");
    // back-to-back soft reset pulse
    @(posedge CLK_SYS_IN);
    WR_STB_IN <= 1'b1;
    ADDR_IN <= 3'h2;
    DATA_IN <= 8'h21;
    @(posedge CLK_SYS_IN);
    DATA_IN <= 8'h25;
    @(negedge CLK_SYS_IN);
    n = int'(srst === 1'b1);
    @(posedge CLK_SYS_IN);
    WR_STB_IN <= 1'b0;
    repeat (9) begin
      @(negedge CLK_SYS_IN);
      n += int'(srst === 1'b1);
    end
    chk("soft reset span", 8'h04, 8'(n));
    chk("soft reset released", 8'h00, {7'h0, srst});
    rd(3'h2, 8'h25, 8'hff);
    rd(3'h3, 8'h03, 8'h03);
    $display("test soft reset done");
    // second-generation status
    MODE_IN <= 3'h2;
    i_drv.pulse(1'b0);
    i_drv.pulse(1'b0);
    i_drv.pulse(1'b0);
    i_drv.pulse(1'b1);
    i_drv.set_gate(1'b1);
    repeat (3) @(posedge CLK_SYS_IN);
    rd(3'h1, 8'b1111_1110, 8'hff);
    @(negedge CLK_SYS_IN);
    chk("dma oe second-gen", 8'h03, {6'h0, drq_oe, irq_oe});
    $display("test second-gen done");
    // compact status latches
    MODE_IN <= 3'h4;
    i_drv.set_gate(1'b0);
    rd(3'h7, 8'h00, 8'h00);
    rd(3'h1, 8'b0010_0011, 8'hff);
    i_drv.set_gate(1'b1);
    i_drv.pulse(1'b0);
    i_drv.pulse(1'b1);
    repeat (3) @(posedge CLK_SYS_IN);
    rd(3'h1, 8'b0011_1111, 8'hff);
    rd(3'h7, 8'h00, 8'h00);
    rd(3'h1, 8'b0010_0011, 8'hff);
    $display("test compact done");
    // baseline: status undriven, dma gating by bit 3
    MODE_IN <= 3'h1;
    v = 8'($urandom);
    {DMA_REQUEST_IN, IRQ_IN, DMA_ACK_LOW_IN, TRANSFER_END_COUNT_IN} <= v[3:0];
    rd(3'h1, 8'h00, 8'h00);
    @(negedge CLK_SYS_IN);
    chk("dma gated", {2'h0, v[3:2], 4'h2}, {2'h0, dma_request, irq, drq_oe, irq_oe, ack_n, tc});
    wr(3'h2, 8'h2d);
    @(negedge CLK_SYS_IN);
    chk("dma enabled", {2'h0, v[3:2], 2'h3, v[1:0]}, {2'h0, dma_request, irq, drq_oe, irq_oe, ack_n, tc});
    $display("test dma gate done");
    repeat (3) @(posedge CLK_SYS_IN);
    give_verdict();
  end
endmodule
